/* File: include/gptp_pkg.sv */
// Constants and types shared by the timer pair
package gptp_pkg;
    // ==========================================================
    // Configuration values
    localparam logic [2:0] CFG_CAT32 = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_SPLIT16 = 3'h4;
    localparam logic [2:0] CFG_PREV_RST = 3'h7;
    // ==========================================================
    // Reset values and first load on entering clock mode
    localparam logic [15:0] CNT_RST = 16'hFFFF;
    localparam logic [15:0] ILA_RST = 16'hFFFF;
    localparam logic [7:0] PRE_RST = 8'h00;
    localparam logic [31:0] RTC_FIRST_LOAD = 32'h0000_0001;
    // ==========================================================
    // Clock-input division: input rate over tick rate
    localparam int RTC_IN_HZ = 32768;
    localparam int RTC_TICK_HZ = 1;
    localparam int RTC_DIV = RTC_IN_HZ / RTC_TICK_HZ;
    // ==========================================================
    // Event bit positions
    localparam int EV_FIRST = 0;
    localparam int EV_SECOND = 1;
    localparam int EV_MATCH = 2;
    localparam int EV_W = 3;
    // ==========================================================
    // Mode field encoding
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_ONESHOT = 2'h1,
        MODE_PERIODIC = 2'h2
    } gptp_mode_e;
    // ==========================================================
    // Static control bits
    typedef struct packed {
        logic [1:0] adc_en;
        logic [1:0] freeze;
        logic clk_ovr;
    } gptp_ctl_s;
endpackage

/* File: src/gptp_top.sv */
// Timer pair: 32-bit timer, real-time clock or two 16-bit timers
`timescale 1ns/1ns
`default_nettype none
module gptp_top #(
    parameter int RTC_DIV = gptp_pkg::RTC_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration and modes
    input wire logic [2:0] i_cfg,
    input wire gptp_pkg::gptp_mode_e i_first_mode,
    input wire gptp_pkg::gptp_mode_e i_second_mode,
    input wire gptp_pkg::gptp_ctl_s i_ctl,
    // Enable pulses
    input wire logic [1:0] i_en_set,
    input wire logic [1:0] i_en_clr,
    // Load writes
    input wire logic [31:0] i_wdata,
    input wire logic [1:0] i_ila_wr,
    input wire logic [1:0] i_pre_wr,
    input wire logic [31:0] i_match,
    // Events
    input wire logic [gptp_pkg::EV_W-1:0] i_mask,
    input wire logic [gptp_pkg::EV_W-1:0] i_clr,
    // Outside world
    input wire logic i_debug_halt,
    input wire logic i_rtc_pin,
    // Status
    output logic [31:0] o_count_first,
    output logic [15:0] o_count_second,
    output logic [1:0] o_run_en,
    output logic [gptp_pkg::EV_W-1:0] o_raw,
    output logic [gptp_pkg::EV_W-1:0] o_masked,
    output logic o_irq,
    output logic o_adc_trig
);
    import gptp_pkg::*;

    // ==========================================================
    // State
    logic [15:0] cnt_ff [2];
    logic [15:0] ila_ff [2];
    logic [7:0] pre_ff [2];
    logic [7:0] pcnt_ff [2];
    logic [15:0] nxt_cnt [2];
    logic [15:0] nxt_ila [2];
    logic [7:0] nxt_pre [2];
    logic [1:0] en_ff, nxt_en;
    logic [EV_W-1:0] raw_ff, nxt_raw, ev;
    logic trig_ff, nxt_trig;
    logic [2:0] cfg_prev_ff;
    logic sync1_ff, sync2_ff, sync3_ff;
    logic [15:0] div_ff, nxt_div;

    // ==========================================================
    // Mode decode
    // mode select
    wire mode32 = (i_cfg == CFG_CAT32);
    wire mode_rtc = (i_cfg == CFG_RTC);
    wire mode16 = (i_cfg == CFG_SPLIT16);
    wire rtc_enter = mode_rtc & (cfg_prev_ff != CFG_RTC);
    gptp_mode_e tmode [2];
    assign tmode[0] = i_first_mode;
    assign tmode[1] = i_second_mode;

    // ==========================================================
    // Split 16-bit timers
    logic [1:0] tick16, pz, to16, os16;
    logic [15:0] c16 [2];
    logic [7:0] p16 [2];
    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : g_t
        assign tick16[gi] = mode16 & en_ff[gi]
            & ~(i_ctl.freeze[gi] & i_debug_halt);
        assign pz[gi] = (pcnt_ff[gi] == 8'h00);
        assign to16[gi] = tick16[gi] & pz[gi]
            & (cnt_ff[gi] == 16'h0000);
        assign os16[gi] = (tmode[gi] == MODE_ONESHOT);
        assign c16[gi] = to16[gi] ? ila_ff[gi]
            : (tick16[gi] & pz[gi]) ? cnt_ff[gi] - 16'h0001
            : cnt_ff[gi];
        assign p16[gi] = ~tick16[gi] ? pcnt_ff[gi]
            : pz[gi] ? pre_ff[gi] : pcnt_ff[gi] - 8'h01;
    end

    // ==========================================================
    // Cascaded 32-bit timer
    wire [31:0] w32 = {cnt_ff[1], cnt_ff[0]};
    wire [31:0] ila32 = {ila_ff[1], ila_ff[0]};
    wire tick32 = mode32 & en_ff[0]
        & ~(i_ctl.freeze[0] & i_debug_halt);
    wire to32 = tick32 & (w32 == 32'h0000_0000);
    wire os32 = (tmode[0] == MODE_ONESHOT);
    wire [31:0] c32 = to32 ? ila32
        : tick32 ? w32 - 32'h0000_0001 : w32;

    // ==========================================================
    // Real-time clock input and divider
    // edge of synchronised pin
    wire rtc_rise = sync2_ff & ~sync3_ff;
    wire rtc_run = mode_rtc & en_ff[0];
    wire sec = rtc_run & rtc_rise
        & (div_ff == 16'(RTC_DIV - 1));
    assign nxt_div = ~rtc_run ? 16'h0000
        : sec ? 16'h0000
        : rtc_rise ? div_ff + 16'h0001 : div_ff;
    wire frz_rtc = (|i_ctl.freeze) & i_debug_halt & ~i_ctl.clk_ovr;
    wire rtc_tick = sec & ~frz_rtc;
    wire rtc_hit = rtc_tick & (w32 == i_match);
    // up count, first load of one
    wire [31:0] r32 = rtc_enter ? RTC_FIRST_LOAD
        : rtc_hit ? 32'h0000_0000
        : rtc_tick ? w32 + 32'h0000_0001 : w32;
    wire [31:0] nxt32 = mode32 ? c32 : r32;

    // ==========================================================
    // Next values of counters and load registers
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_cnt[i] = mode16 ? c16[i] : nxt32[16*i +: 16];
            nxt_ila[i] = ila_ff[i];
            nxt_pre[i] = i_pre_wr[i] ? i_wdata[7:0] : pre_ff[i];
            if (i_ila_wr[i] & (mode16 | (i == 1))) begin
                nxt_ila[i] = i_wdata[15:0];
                if (mode16) begin
                    nxt_cnt[i] = i_wdata[15:0];
                end
            end
        end
        if (i_ila_wr[0] & ~mode16) begin
            nxt_ila[0] = i_wdata[15:0];
            nxt_ila[1] = i_wdata[31:16];
            if (mode32) begin
                nxt_cnt[0] = i_wdata[15:0];
                nxt_cnt[1] = i_wdata[31:16];
            end
        end
    end

    // ==========================================================
    // Enables, events and flags
    // one-shot clears its enable
    assign nxt_en[0] = i_en_set[0] | (en_ff[0] & ~i_en_clr[0]
        & ~((to32 & os32) | (to16[0] & os16[0])));
    assign nxt_en[1] = i_en_set[1]
        | (en_ff[1] & ~i_en_clr[1] & ~(to16[1] & os16[1]));
    assign ev[EV_FIRST] = to32 | to16[0];
    assign ev[EV_SECOND] = to16[1];
    assign ev[EV_MATCH] = rtc_hit;
    assign nxt_raw = ev | (raw_ff & ~i_clr);
    assign nxt_trig = |(ev[EV_SECOND:EV_FIRST] & i_ctl.adc_en);

    // ==========================================================
    // Registers
    // reset to idle, counters and load registers all-ones, prescalers zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < 2; i++) begin
                cnt_ff[i] <= CNT_RST;
                ila_ff[i] <= ILA_RST;
                pre_ff[i] <= PRE_RST;
                pcnt_ff[i] <= PRE_RST;
            end
            en_ff <= 2'h0;
            raw_ff <= '0;
            trig_ff <= 1'b0;
            cfg_prev_ff <= CFG_PREV_RST;
            div_ff <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
                ila_ff[i] <= nxt_ila[i];
                pre_ff[i] <= nxt_pre[i];
                pcnt_ff[i] <= p16[i];
            end
            en_ff <= nxt_en;
            raw_ff <= nxt_raw;
            trig_ff <= nxt_trig;
            cfg_prev_ff <= i_cfg;
            div_ff <= nxt_div;
        end
    end

    // Pin synchroniser and edge stage
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= i_rtc_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // ==========================================================
    // Outputs
    // cascaded count view, first 16-bit timer alone in split mode
    assign o_count_first = mode16 ? {16'h0000, cnt_ff[0]} : w32;
    assign o_count_second = cnt_ff[1];
    assign o_run_en = en_ff;
    assign o_raw = raw_ff;
    assign o_masked = raw_ff & i_mask;
    assign o_irq = |o_masked;
    assign o_adc_trig = trig_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    AST_OS_STOP: assert property (
        to32 & os32 & ~i_en_set[0] |=> !en_ff[0])
        else $error("one-shot did not stop");
    AST_RELOAD: assert property (
        to32 & ~i_ila_wr[0] |=> w32 == $past(ila32))
        else $error("cascade reload wrong");
    AST_STICKY: assert property (
        raw_ff[EV_FIRST] & ~i_clr[EV_FIRST] |=> raw_ff[EV_FIRST])
        else $error("time-out flag lost");
    AST_IRQ: assert property (
        raw_ff[EV_MATCH] & i_mask[EV_MATCH] |-> o_irq)
        else $error("interrupt missing");
    AST_ADC: assert property (
        to16[1] & i_ctl.adc_en[1] |=> o_adc_trig)
        else $error("trigger missing");
    AST_ADC_OFF: assert property (
        ~mode_rtc & ~i_ctl.adc_en[0] & ~i_ctl.adc_en[1]
        |=> !o_adc_trig)
        else $error("trigger while disabled");
    AST_LOAD16: assert property (
        mode16 & i_ila_wr[1] |=> cnt_ff[1] == $past(i_wdata[15:0]))
        else $error("load rewrite not taken");
    AST_FREEZE: assert property (
        mode32 & i_ctl.freeze[0] & i_debug_halt & ~i_ila_wr[0]
        |=> $stable(w32))
        else $error("frozen counter moved");
    AST_WRAP: assert property (
        rtc_hit & ~rtc_enter |=> w32 == 32'h0000_0000)
        else $error("no roll to zero");
    AST_ENTER: assert property (
        rtc_enter |=> w32 == RTC_FIRST_LOAD)
        else $error("clock start value wrong");
    AST_PRESC: assert property (
        tick16[0] & ~pz[0] & ~i_ila_wr[0] |=> $stable(cnt_ff[0]))
        else $error("prescale ignored");
    AST_SPLIT: assert property (
        mode16 & i_ila_wr[0] & ~i_ila_wr[1] |=> $stable(ila_ff[1]))
        else $error("split write leaked");

    COV_OS32: cover property (to32 & os32);
    COV_PER16: cover property (to16[1] & ~os16[1] ##1 en_ff[1]);
    COV_RTC: cover property (rtc_hit);
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the timer pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gptp_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] cfg = CFG_CAT32;
    gptp_mode_e m1 = MODE_OFF;
    gptp_mode_e m2 = MODE_OFF;
    gptp_ctl_s ctl = '0;
    logic [1:0] en_set = 2'h0, en_clr = 2'h0, ila_wr = 2'h0, pre_wr = 2'h0;
    logic [31:0] wdata = 32'h0, match = 32'h0;
    logic [2:0] mask = 3'h0, clr = 3'h0;
    logic halt = 1'b0, pin = 1'b0, pin_run = 1'b0;
    logic [31:0] cnt1;
    logic [15:0] cnt2;
    logic [1:0] run;
    logic [2:0] raw, msk;
    logic irq, trig;
    int bad_count = 0;
    int total_checks = 0;
    int n;
    logic [31:0] v;

    gptp_top #(.RTC_DIV(4)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_cfg(cfg),
        .i_first_mode(m1), .i_second_mode(m2), .i_ctl(ctl),
        .i_en_set(en_set), .i_en_clr(en_clr), .i_wdata(wdata),
        .i_ila_wr(ila_wr), .i_pre_wr(pre_wr), .i_match(match),
        .i_mask(mask), .i_clr(clr), .i_debug_halt(halt),
        .i_rtc_pin(pin), .o_count_first(cnt1), .o_count_second(cnt2),
        .o_run_en(run), .o_raw(raw), .o_masked(msk), .o_irq(irq),
        .o_adc_trig(trig)
    );

    always #50 i_clk = ~i_clk;
    // Slow clock input, four system clocks per period
    always begin
        #200;
        if (pin_run) pin = ~pin;
    end

    // ==========================================
    // Helpers
    task automatic tick(int k);
        repeat (k) @(posedge i_clk);
        #10;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [1:0] il, logic [1:0] pr, logic [31:0] d);
        wdata = d;
        ila_wr = il;
        pre_wr = pr;
        tick(1);
        ila_wr = 2'h0;
        pre_wr = 2'h0;
    endtask
    task automatic pulse_en(logic [1:0] s, logic [1:0] c);
        en_set = s;
        en_clr = c;
        tick(1);
        en_set = 2'h0;
        en_clr = 2'h0;
    endtask
    task automatic pulse_clr(logic [2:0] c);
        clr = c;
        tick(1);
        clr = 3'h0;
    endtask
    task automatic wait_change();
        v = cnt1;
        n = 0;
        while (cnt1 === v && n < 60) begin
            tick(1);
            n++;
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk(cnt1, 32'hFFFF_FFFF);
        chk(32'(cnt2), 32'hFFFF);
        chk(32'({run, raw, trig}), 32'h0);
    endtask
    task automatic t_cat_oneshot();
        m1 = MODE_ONESHOT;
        m2 = MODE_PERIODIC;
        ctl.adc_en = 2'h1;
        mask = 3'h1;
        wr(2'h1, 2'h0, 32'h5);
        chk(cnt1, 32'h5);
        pulse_en(2'h1, 2'h0);
        tick(5);
        chk(cnt1, 32'h0);
        tick(1);
        chk(cnt1, 32'h5);
        chk(32'({run, raw, msk, irq}), 32'h13);
        chk(32'(trig), 32'h1);
        tick(1);
        chk(cnt1, 32'h5);
        chk(32'({trig, raw}), 32'h1);
        pulse_clr(3'h1);
        chk(32'({raw, irq}), 32'h0);
    endtask
    task automatic t_cat_periodic();
        m1 = MODE_PERIODIC;
        m2 = MODE_ONESHOT;
        ctl.adc_en = 2'h0;
        wr(2'h1, 2'h0, 32'h0001_0000);
        chk(cnt1, 32'h0001_0000);
        chk(32'(cnt2), 32'h1);
        pulse_en(2'h1, 2'h0);
        tick(1);
        chk(cnt1, 32'h0000_FFFF);
        ctl.freeze = 2'h1;
        halt = 1'b1;
        v = cnt1;
        tick(3);
        chk(cnt1, v);
        halt = 1'b0;
        tick(1);
        chk(cnt1, v - 32'h1);
        wr(2'h1, 2'h0, 32'h3);
        chk(cnt1, 32'h3);
        tick(4);
        chk(cnt1, 32'h3);
        chk(32'({run, raw[0]}), 32'h3);
        chk(32'(trig), 32'h0);
        tick(1);
        pulse_en(2'h0, 2'h1);
        pulse_clr(3'h1);
        ctl.freeze = 2'h0;
    endtask
    task automatic t_split();
        cfg = CFG_SPLIT16;
        ctl.adc_en = 2'h2;
        mask = 3'h2;
        wr(2'h0, 2'h2, 32'h1);
        tick(1);
        wr(2'h2, 2'h0, 32'h2);
        tick(1);
        wr(2'h1, 2'h0, 32'hABCD_0003);
        chk(cnt1, 32'h3);
        chk(32'(cnt2), 32'h2);
        pulse_en(2'h3, 2'h0);
        tick(1);
        chk(cnt1, 32'h2);
        tick(3);
        chk(32'(cnt2), 32'h0);
        chk(cnt1, 32'h3);
        chk(32'({trig, raw[0]}), 32'h1);
        for (int i = 0; i < 6 && raw[1] !== 1'b1; i++) tick(1);
        chk(32'({run, cnt2}), 32'h1_0002);
        chk(32'({raw, msk, irq}), 32'h35);
        chk(32'(trig), 32'h1);
        pulse_en(2'h0, 2'h3);
        pulse_clr(3'h3);
    endtask
    task automatic t_rtc();
        cfg = CFG_RTC;
        match = 32'h3;
        ctl = '0;
        ctl.freeze = 2'h3;
        ctl.clk_ovr = 1'b1;
        halt = 1'b1;
        mask = 3'h4;
        tick(1);
        chk(cnt1, RTC_FIRST_LOAD);
        wr(2'h1, 2'h0, 32'h10);
        chk(cnt1, 32'h1);
        pulse_en(2'h1, 2'h0);
        pin_run = 1'b1;
        wait_change();
        chk(cnt1, 32'h2);
        wait_change();
        chk(32'(n), 32'h10);
        chk(cnt1, 32'h3);
        wait_change();
        chk(cnt1, 32'h0);
        chk(32'({run[0], raw, msk, irq}), 32'hC9);
        pulse_clr(3'h4);
        chk(32'({raw, msk, irq}), 32'h0);
        pin_run = 1'b0;
        halt = 1'b0;
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge i_clk);
        #10;
        i_reset = 1'b0;
        t_reset();
        t_cat_oneshot();
        t_cat_periodic();
        t_split();
        t_rtc();
        stop_test();
    end
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
